// file: dv/hpsel_host_model.sv
// Host controller model driving the byte register port
`timescale 1ns/1ns
module hpsel_host_model (
  input  wire logic       sys_clk_i,
  output logic            acc_wr_o,
  output logic            acc_rd_o,
  output logic      [6:0] acc_off_o,
  output logic      [7:0] acc_wdata_o,
  input  wire logic [7:0] acc_rdata_i,
  input  wire logic       acc_done_i
);
  // Quiet port at time zero
  initial begin
    acc_wr_o    = 1'b0;
    acc_rd_o    = 1'b0;
    acc_off_o   = 7'h00;
    acc_wdata_o = 8'h00;
  end
  // One access: request pulse, answer taken one cycle later
  task automatic xfer(input logic wr, input logic [6:0] off, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(posedge sys_clk_i);
    #1;
    acc_wr_o    = wr;
    acc_rd_o    = ~wr;
    acc_off_o   = off;
    acc_wdata_o = d;
    @(posedge sys_clk_i);
    #1;
    acc_wr_o    = 1'b0;
    acc_rd_o    = 1'b0;
    acc_off_o   = ~off; // No stale address after release
    acc_wdata_o = ~d;
    q           = acc_rdata_i;
    ok          = acc_done_i;
  endtask : xfer
  // Trigger finished once it reads zero; bounded so a hang is seen
  task automatic poll(output logic ok);
    logic [7:0] q;
    logic       d;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      xfer(1'b0, 7'h04, 8'h00, q, d);
      ok = d && (q === 8'h00);
    end
  endtask : poll
endmodule : hpsel_host_model

// file: dv/testbench.sv
// Self-checking bench for guard, page window and channel selector
`timescale 1ns/1ns
module testbench;
  import hpsel_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        acc_wr;
  logic        acc_rd;
  logic        acc_done;
  logic        lockout;
  logic [6:0]  acc_off;
  logic [7:0]  acc_wdata;
  logic [7:0]  acc_rdata;
  logic [7:0]  page;
  logic [7:0]  q;
  logic [63:0] cfg;
  logic        ok;
  logic [7:0]  rsv [4] = '{8'h07, 8'h09, 8'h0e, 8'hff};
  int          failures     = 0;
  int          total_checks = 0;

  // Clock at 125 MHz
  always #4 sys_clk_i = ~sys_clk_i;

  hpsel_regs hpsel_regs_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .acc_wr_i(acc_wr), .acc_rd_i(acc_rd),
    .acc_off_i(acc_off), .acc_wdata_i(acc_wdata), .acc_rdata_o(acc_rdata), .acc_done_o(acc_done),
    .page_o(page), .lockout_o(lockout), .chan_cfg_o(cfg));
  hpsel_host_model hpsel_host_model_i (
    .sys_clk_i(sys_clk_i), .acc_wr_o(acc_wr), .acc_rd_o(acc_rd), .acc_off_o(acc_off),
    .acc_wdata_o(acc_wdata), .acc_rdata_i(acc_rdata), .acc_done_i(acc_done));

  // Verdict and end of run
  task automatic stop_test();
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Every access, good or refused, must be answered
  task automatic wr(input logic [6:0] o, input logic [7:0] d);
    hpsel_host_model_i.xfer(1'b1, o, d, q, ok);
    chk("done", 1'b1, ok);
  endtask : wr
  task automatic rd(input logic [6:0] o, input logic [7:0] e);
    hpsel_host_model_i.xfer(1'b0, o, 8'h00, q, ok);
    chk("done", 1'b1, ok);
    chk("rdata", e, q);
  endtask : rd
  task automatic trig(input logic [7:0] d);
    wr(7'h04, d);
    hpsel_host_model_i.poll(ok);
    chk("trigger idle", 1'b1, ok);
  endtask : trig

  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    rd(7'h7e, 8'h00);
    rd(7'h7f, 8'h00);
    wr(7'h7f, 8'h0c);
    chk("page", 8'h0c, page);
    rd(7'h02, 8'h01);
    rd(7'h03, 8'h00);
    wr(7'h05, 8'h03);
    wr(7'h06, 8'hc8);
    wr(7'h02, 8'h05);
    trig(8'h01);
    chk("cfg", {16'h0000, 16'hc803, 16'h0000, 16'hc803}, cfg);
    // Unused selector bits must not matter
    wr(7'h05, 8'h04);
    wr(7'h06, 8'h00);
    wr(7'h02, 8'h7a);
    trig(8'h01);
    chk("cfg", {16'h0004, 16'hc803, 16'h0004, 16'hc803}, cfg);
    wr(7'h02, 8'h04);
    trig(8'h02);
    rd(7'h05, 8'h03);
    rd(7'h06, 8'hc8);
    // Lockout freezes all but the guard
    wr(7'h7e, 8'h80);
    chk("lockout", 1'b1, lockout);
    wr(7'h02, 8'h0f);
    wr(7'h7f, 8'h05);
    wr(7'h04, 8'h01);
    rd(7'h7e, 8'h81);
    rd(7'h02, 8'h04);
    chk("page", 8'h0c, page);
    chk("cfg", {16'h0004, 16'hc803, 16'h0004, 16'hc803}, cfg);
    wr(7'h7e, 8'h00);
    rd(7'h7e, 8'h00);
    // Reserved pages and pages past the last valid one refuse writes
    foreach (rsv[i]) begin
      wr(7'h7f, rsv[i]);
      wr(7'h05, 8'h55);
      rd(7'h7e, 8'h01);
      wr(7'h7f, 8'h0c);
      rd(7'h05, 8'h03);
    end
    stop_test();
  end

  // Watchdog, far beyond the few dozen accesses above
  initial begin
    #20000;
    failures++;
    stop_test();
  end
endmodule : testbench

// file: hdl/hpsel_chan_bank.sv
// Per-channel configuration storage, written by mask
`timescale 1ns/1ns
module hpsel_chan_bank
  import hpsel_pkg::*;
#(
  parameter int N_CH = hpsel_pkg::NUM_CHAN,
  parameter int W    = hpsel_pkg::CFG_W
) (
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              apply_i,
  input  wire logic [N_CH-1:0]   mask_i,
  input  wire logic [W-1:0]      cfg_i,
  output logic      [N_CH*W-1:0] chan_cfg_o
);
  logic [W-1:0] cfg_mem [N_CH];

  // Every selected channel takes the same settings in one step
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < N_CH; i++) begin
        cfg_mem[i] <= '0;
      end
    end else if (apply_i) begin
      for (int i = 0; i < N_CH; i++) begin
        if (mask_i[i]) begin
          cfg_mem[i] <= cfg_i;
        end
      end
    end
  end

  // Flattened view for the loop channels
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      chan_cfg_o[i*W +: W] = cfg_mem[i];
    end
  end
endmodule : hpsel_chan_bank

// file: hdl/hpsel_pkg.sv
// Constants for the host port guard, page window and loop channel selector
package hpsel_pkg;
  localparam int          PAGE_W        = 8;
  localparam int          OFF_W         = 7;
  localparam int          ADDR_W        = PAGE_W + OFF_W;
  localparam int          NUM_CHAN      = 4;
  localparam int          MASK_W        = 7;
  localparam int          CFG_W         = 16;
  // Byte addresses inside the paged space
  localparam logic [14:0] ADDR_GUARD    = 15'h05fe;
  localparam logic [14:0] ADDR_WINDOW   = 15'h05ff;
  localparam logic [14:0] ADDR_SEL_LO   = 15'h0602;
  localparam logic [14:0] ADDR_SEL_HI   = 15'h0603;
  localparam logic [14:0] ADDR_TRIG     = 15'h0604;
  localparam logic [14:0] ADDR_BW       = 15'h0605;
  localparam logic [14:0] ADDR_BW_VAR   = 15'h0606;
  // Field positions
  localparam int          GUARD_LOCK_B  = 7;
  localparam int          GUARD_STAT_B  = 0;
  localparam int          TRIG_APPLY_B  = 0;
  localparam int          TRIG_FETCH_B  = 1;
  // Reset values
  localparam logic [7:0]  GUARD_RST     = 8'h00;
  localparam logic [7:0]  WINDOW_RST    = 8'h00;
  localparam logic [6:0]  SEL_RST       = 7'h01;
  localparam logic [7:0]  BW_RST        = 8'h00;
  localparam logic [7:0]  BW_VAR_RST    = 8'h00;
  localparam logic [1:0]  TRIG_RST      = 2'h0;
  // Reserved page numbers and last valid page
  localparam logic [7:0]  PAGE_RSV_A    = 8'h07;
  localparam logic [7:0]  PAGE_RSV_B    = 8'h09;
  localparam logic [7:0]  PAGE_LAST     = 8'h0d;
endpackage : hpsel_pkg

// file: hdl/hpsel_regs.sv
// Host port guard, page window, loop channel selector and trigger logic
`timescale 1ns/1ns
module hpsel_regs
  import hpsel_pkg::*;
(
  input  wire logic                              sys_clk_i,
  input  wire logic                              resetn_i,
  input  wire logic                              acc_wr_i,
  input  wire logic                              acc_rd_i,
  input  wire logic [hpsel_pkg::OFF_W-1:0]       acc_off_i,
  input  wire logic [7:0]                        acc_wdata_i,
  output logic      [7:0]                        acc_rdata_o,
  output logic                                   acc_done_o,
  output logic      [hpsel_pkg::PAGE_W-1:0]      page_o,
  output logic                                   lockout_o,
  output logic      [hpsel_pkg::NUM_CHAN*hpsel_pkg::CFG_W-1:0] chan_cfg_o
);
  import hpsel_pkg::*;

  logic              lock_reg;
  logic              stat_reg;
  logic [7:0]        window_reg;
  logic [MASK_W-1:0] sel_reg;
  logic [1:0]        trig_reg;
  logic [7:0]        bw_reg;
  logic [7:0]        bw_var_reg;
  logic [7:0]        rdata_reg;
  logic              done_reg;
  logic [ADDR_W-1:0] addr;
  logic              acc;
  logic              page_ok;
  logic              guard_hit;
  logic              guard_sel;
  logic              window_sel;
  logic              blocked;
  logic              wr_ok;
  logic [NUM_CHAN*CFG_W-1:0] bank_cfg;
  logic [CFG_W-1:0]  fetch_cfg;

  // Reserved pages are refused
  function automatic logic page_valid(input logic [7:0] p);
    page_valid = (p <= PAGE_LAST) && (p != PAGE_RSV_A) && (p != PAGE_RSV_B);
  endfunction : page_valid

  // Lowest set bit wins if the host breaks the one-hot convention
  function automatic logic [1:0] first_chan(input logic [MASK_W-1:0] m);
    first_chan = 2'd0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_chan = 2'(i);
      end
    end
  endfunction : first_chan

  // Address forming and access qualification
  assign addr      = {window_reg, acc_off_i};
  assign acc       = acc_wr_i | acc_rd_i;
  // Guard and window sit at the top two offsets of every page, not only page 11
  assign guard_sel  = (acc_off_i == ADDR_GUARD[OFF_W-1:0]);
  assign window_sel = (acc_off_i == ADDR_WINDOW[OFF_W-1:0]);
  assign guard_hit  = guard_sel || window_sel;
  // Guard and window stay reachable from any page so a bad page can be left
  assign page_ok   = page_valid(window_reg) || guard_hit;
  assign blocked   = lock_reg && !guard_sel;
  assign wr_ok     = acc_wr_i && page_ok && !blocked;
  assign fetch_cfg = bank_cfg[first_chan(sel_reg)*CFG_W +: CFG_W];

  // Guard register: lockout and last-access status
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_reg <= GUARD_RST[GUARD_LOCK_B];
      stat_reg <= GUARD_RST[GUARD_STAT_B];
    end else begin
      if (wr_ok && guard_sel) begin
        lock_reg <= acc_wdata_i[GUARD_LOCK_B];
      end
      if (acc) begin
        stat_reg <= !page_ok || (acc_wr_i && blocked);
      end
    end
  end

  // Page window register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      window_reg <= WINDOW_RST;
    end else if (wr_ok && window_sel) begin
      window_reg <= acc_wdata_i;
    end
  end

  // Channel selector; upper byte is reserved
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_reg <= SEL_RST;
    end else if (wr_ok && addr == ADDR_SEL_LO) begin
      sel_reg <= acc_wdata_i[MASK_W-1:0];
    end
  end

  // Trigger: taken when idle, runs one cycle, then reads zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_reg <= TRIG_RST;
    end else if (trig_reg != 2'h0) begin
      trig_reg <= 2'h0;
    end else if (wr_ok && addr == ADDR_TRIG) begin
      if (acc_wdata_i[TRIG_FETCH_B]) begin
        trig_reg <= 2'h2;
      end else if (acc_wdata_i[TRIG_APPLY_B]) begin
        trig_reg <= 2'h1;
      end
    end
  end

  // Visible configuration; a fetch overrides a host write in the same cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bw_reg     <= BW_RST;
      bw_var_reg <= BW_VAR_RST;
    end else if (trig_reg[TRIG_FETCH_B]) begin
      bw_reg     <= fetch_cfg[7:0];
      bw_var_reg <= fetch_cfg[15:8];
    end else begin
      if (wr_ok && addr == ADDR_BW) begin
        bw_reg <= acc_wdata_i;
      end
      if (wr_ok && addr == ADDR_BW_VAR) begin
        bw_var_reg <= acc_wdata_i;
      end
    end
  end

  // Read data and done, one cycle after the access
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= acc;
      if (acc_rd_i && guard_sel) begin
        // Status shown is that of the access before this read
        rdata_reg <= {lock_reg, 6'h00, stat_reg};
      end else if (acc_rd_i && window_sel) begin
        rdata_reg <= window_reg;
      end else if (acc_rd_i && page_ok) begin
        case (addr)
          ADDR_SEL_LO: rdata_reg <= {1'b0, sel_reg};
          ADDR_TRIG:   rdata_reg <= {6'h00, trig_reg};
          ADDR_BW:     rdata_reg <= bw_reg;
          ADDR_BW_VAR: rdata_reg <= bw_var_reg;
          default:     rdata_reg <= 8'h00;
        endcase
      end else if (acc_rd_i) begin
        rdata_reg <= 8'h00;
      end
    end
  end

  hpsel_chan_bank #(
    .N_CH (NUM_CHAN),
    .W    (CFG_W)
  ) u_bank (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .apply_i    (trig_reg == 2'h1),
    .mask_i     (sel_reg[NUM_CHAN-1:0]),
    .cfg_i      ({bw_var_reg, bw_reg}),
    .chan_cfg_o (bank_cfg)
  );

  assign acc_rdata_o = rdata_reg;
  assign acc_done_o  = done_reg;
  assign page_o      = window_reg;
  assign lockout_o   = lock_reg;
  assign chan_cfg_o  = bank_cfg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_LOCK_HOLD: assert property (lock_reg && acc_wr_i && window_sel |=> $stable(window_reg))
    else $error("window changed while locked");
  AST_LOCK_FREEZE: assert property (lock_reg && acc_wr_i && !guard_sel |=> $stable(sel_reg) && trig_reg == 2'h0)
    else $error("selector or trigger changed while locked");
  AST_UNLOCK_WR: assert property (!lock_reg && acc_wr_i && window_sel |=> window_reg == $past(acc_wdata_i))
    else $error("window write lost while open");
  AST_STAT_SET: assert property (acc_wr_i && blocked |=>
                                 stat_reg ##1 (!$past(acc_rd_i && guard_sel) || rdata_reg[GUARD_STAT_B]))
    else $error("failed access not flagged");
  AST_STAT_CLR: assert property (acc && page_ok && !(acc_wr_i && blocked) |=> !stat_reg)
    else $error("status not cleared after good access");
  AST_RSV_PAGE: assert property (acc && !page_valid(window_reg) && acc_off_i < 7'h7e |=> stat_reg)
    else $error("reserved page access not flagged");
  AST_ADDR_FORM: assert property (wr_ok && window_reg == 8'h0c && acc_off_i == 7'h02 |=> sel_reg == $past(acc_wdata_i[6:0]))
    else $error("page 12 offset 2 did not reach selector");
  AST_APPLY: assert property (trig_reg == 2'h1 && sel_reg[0] |=> chan_cfg_o[15:0] == $past({bw_var_reg, bw_reg}))
    else $error("apply missed channel 0");
  AST_FETCH: assert property (trig_reg == 2'h2 && sel_reg[3:0] == 4'h4 |=> bw_reg == $past(bank_cfg[39:32]))
    else $error("fetch loaded wrong channel");
  AST_TRIG_CLR: assert property (trig_reg != 2'h0 |=>
                                 trig_reg == 2'h0 ##1 (trig_reg == 2'h0 || $past(wr_ok && addr == ADDR_TRIG)))
    else $error("trigger not cleared");
  AST_DONE: assert property (acc |=> acc_done_o)
    else $error("access not acknowledged");

  COV_APPLY_MULTI: cover property (trig_reg == 2'h1 && sel_reg[1:0] == 2'h3);
  COV_FETCH:       cover property (trig_reg == 2'h2);
  COV_LOCK_BLOCK:  cover property (acc_wr_i && blocked);
  COV_RSV_PAGE:    cover property (acc && !page_ok);
endmodule : hpsel_regs
